// *** tb/core_side_model.sv ***
// Behavioural model of the core's wait state facing the bank; all other core inputs pass straight through.
`timescale 1ns/1ps
`default_nettype none
module core_side_model
    import sys_ctrl_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire core_in_s  req_i,
    input  wire core_out_s resp_i,
    output core_in_s       core_o
);
    logic waiting_ff;

    // The core stays parked after a wait until the bank reports a wake or a completion.
    always_ff @(posedge clk_i) begin
        if (rst_i || resp_i.wake || resp_i.wfe_done) begin
            waiting_ff <= 1'b0;
        end else if (req_i.wfe_exec) begin
            waiting_ff <= 1'b1;
        end
    end

    always_comb begin
        core_o         = req_i;
        core_o.waiting = waiting_ff;
    end
endmodule
`default_nettype wire

// *** tb/sys_ctrl_checker.sv ***
// Concurrent checks on the ports of the system control bank.
`timescale 1ns/1ps
`default_nettype none
module sys_ctrl_checker
    import sys_ctrl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        priv_i,
    input  wire logic [31:0] rdata_o,
    input  wire logic        bus_err_o,
    input  wire core_in_s    core_i,
    input  wire logic        ext_event_i,
    input  wire core_out_s   core_o
);
    // ****************************************************************
    // Shadow registers
    // ****************************************************************
    // Shadows track accepted writes so field-dependent outputs can be judged.
    logic [31:0] lp_ff;
    logic [31:0] cc_ff;
    logic [2:0]  split_ff;
    logic [7:0]  grp_mask;
    logic        exp_pre;
    logic        bank_wr;
    assign bank_wr = wr_i && priv_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_ff    <= RST_LOW_POWER_CONTROL;
            cc_ff    <= RST_CORE_CONFIGURATION_CONTROL;
            split_ff <= 3'h0;
        end else if (bank_wr) begin
            if (addr_i == OFF_LOW_POWER_CONTROL) begin
                lp_ff <= wdata_i;
            end
            if (addr_i == OFF_CORE_CONFIGURATION_CONTROL) begin
                cc_ff <= wdata_i;
            end
            if (addr_i == OFF_INTERRUPT_RESET_CONTROL && wdata_i[31:16] == WRITE_UNLOCK_KEY) begin
                split_ff <= wdata_i[10:8];
            end
        end
    end

    always_comb begin
        case (split_ff)
            SPLIT_GROUP_3: grp_mask = 8'hE0;
            SPLIT_GROUP_2: grp_mask = 8'hC0;
            SPLIT_GROUP_1: grp_mask = 8'h80;
            SPLIT_GROUP_0: grp_mask = 8'h00;
            default:       grp_mask = 8'hF0;
        endcase
    end
    assign exp_pre = (core_i.pend_prio & grp_mask) < (core_i.run_prio & grp_mask);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_key_reset_wr;
        bank_wr && addr_i == OFF_INTERRUPT_RESET_CONTROL && wdata_i[31:16] == WRITE_UNLOCK_KEY
            && wdata_i[SYS_RESET_REQ_BIT];
    endsequence
    sequence s_one_pulse;
        core_o.system_reset_request ##1 !core_o.system_reset_request;
    endsequence

    a_reset_req_pulse: assert property (s_key_reset_wr |=> s_one_pulse)
        else $error("reset request is not a single pulse after a keyed write");
    a_key_status_read: assert property (rd_i && priv_i && addr_i == OFF_INTERRUPT_RESET_CONTROL
        |=> rdata_o == {UNLOCK_KEY_STATUS, 5'h00, $past(split_ff), 8'h00})
        else $error("interrupt reset control read value wrong");
    a_unpriv_refused: assert property ((rd_i || wr_i) && !priv_i |=> bus_err_o && rdata_o == 32'h0)
        else $error("unprivileged access not refused");
    a_preempt_group: assert property (!$past(rst_i) |-> core_o.preempt == $past(exp_pre))
        else $error("preempt disagrees with group priority");
    a_pend_group: assert property (!$past(rst_i)
        |-> core_o.pend_group == ($past(core_i.pend_prio) & $past(grp_mask)))
        else $error("pending group value wrong");
    a_wake_pending: assert property (core_i.irq_pend_new && core_i.waiting
        && (core_i.irq_pend_enabled || lp_ff[WAKE_ON_PENDING_BIT]) |=> core_o.wake)
        else $error("pending interrupt did not wake");
    a_sleep_on_return: assert property (core_i.handler_return
        |=> core_o.sleep_enter == $past(lp_ff[ON_RETURN_SLEEP_BIT]))
        else $error("sleep on return wrong");
    a_div_zero_policy: assert property (core_i.div_by_zero |=> core_o.div_trap
        == $past(cc_ff[ZERO_DIV_TRAP_BIT]) && core_o.div_quot_zero != core_o.div_trap)
        else $error("divide by zero handling wrong");
    a_misalign_fault: assert property (core_i.misaligned |=> core_o.usage_fault
        == ($past(cc_ff[MISALIGN_TRAP_BIT]) || $past(core_i.multi_or_double)))
        else $error("unaligned fault wrong");
    a_bus_fault_ign: assert property (core_i.load_store_bus_fault && core_i.prio_neg
        |=> core_o.bus_fault_ignored == $past(cc_ff[BUS_FAULT_IGN_BIT])
        && core_o.lockup != core_o.bus_fault_ignored)
        else $error("high priority bus fault handling wrong");
    a_trigger_gate: assert property (core_i.trigger_access && core_i.trigger_unpriv
        |=> core_o.trigger_grant == $past(cc_ff[TRIGGER_ACCESS_BIT])
        && core_o.trigger_deny != core_o.trigger_grant)
        else $error("trigger access gating wrong");
    a_thread_entry: assert property (core_i.thread_return && core_i.other_active
        |=> core_o.thread_ok == $past(cc_ff[THREAD_ANY_BIT])
        && core_o.thread_fault != core_o.thread_ok)
        else $error("thread entry policy wrong");
endmodule

bind system_control_config_regs sys_ctrl_checker u_checker (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .priv_i(priv_i), .rdata_o(rdata_o), .bus_err_o(bus_err_o),
    .core_i(core_i), .ext_event_i(ext_event_i), .core_o(core_o)
);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the system control bank and its core-side model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench
    import sys_ctrl_pkg::*;
;
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic [7:0]  addr_i      = 8'h00;
    logic [31:0] wdata_i     = 32'h0;
    logic        wr_i        = 1'b0;
    logic        rd_i        = 1'b0;
    logic        priv_i      = 1'b0;
    logic        ext_event_i = 1'b0;
    logic [31:0] rdata_o;
    logic        bus_err_o;
    core_in_s    req         = '0;
    core_in_s    core_in;
    core_out_s   core_out;
    logic [8:0]  cfg_view;
    logic [7:0]  masks [5]   = '{8'hF0, 8'hE0, 8'hC0, 8'h80, 8'h00};
    logic [7:0]  pp [2]      = '{8'h40, 8'hA5};
    int          failures    = 0;
    int          n_tests     = 0;

    assign cfg_view = {core_out.div_trap, core_out.usage_fault, core_out.bus_fault_ignored,
        core_out.trigger_grant, core_out.thread_ok, core_out.div_quot_zero, core_out.lockup,
        core_out.trigger_deny, core_out.thread_fault};

    system_control_config_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .priv_i(priv_i), .rdata_o(rdata_o),
        .bus_err_o(bus_err_o), .core_i(core_in), .ext_event_i(ext_event_i), .core_o(core_out));
    core_side_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .resp_i(core_out),
        .core_o(core_in));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // One bus cycle; w selects write, otherwise a read whose data stand after the next edge.
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w, input logic p);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= w;
        rd_i    <= !w;
        priv_i  <= p;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 32'h0, 1'b0, 1'b1);
        `CHK("rdata", e, rdata_o)
    endtask

    task automatic pulse(input core_in_s v);
        @(posedge clk_i);
        req <= v;
        @(posedge clk_i);
        req <= '0;
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        tally_and_finish();
    end

    initial begin
        core_in_s   c;
        logic [7:0] m;
        logic       seen;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(OFF_INTERRUPT_RESET_CONTROL, RST_INTERRUPT_RESET_CONTROL);
        rd_chk(OFF_LOW_POWER_CONTROL, RST_LOW_POWER_CONTROL);
        rd_chk(OFF_CORE_CONFIGURATION_CONTROL, RST_CORE_CONFIGURATION_CONTROL);
        rd_chk(8'h20, 32'h0);
        `CHK("align8", 1'b1, core_out.entry_align8)
        bus(OFF_INTERRUPT_RESET_CONTROL, 32'h12340704, 1'b1, 1'b1);
        `CHK("reset_req", 1'b0, core_out.system_reset_request)
        rd_chk(OFF_INTERRUPT_RESET_CONTROL, 32'hFA050000);
        bus(OFF_INTERRUPT_RESET_CONTROL, 32'h05FA0704, 1'b1, 1'b1);
        `CHK("reset_req", 1'b1, core_out.system_reset_request)
        rd_chk(OFF_INTERRUPT_RESET_CONTROL, 32'hFA050700);
        for (int s = 3; s < 8; s++) begin
            bus(OFF_INTERRUPT_RESET_CONTROL, {WRITE_UNLOCK_KEY, 5'h00, 3'(s), 8'h00}, 1'b1, 1'b1);
            m = masks[s - 3];
            for (int k = 0; k < 2; k++) begin
                c = '0;
                c.pend_prio = pp[k];
                c.run_prio = 8'hB0;
                pulse(c);
                `CHK("preempt", (pp[k] & m) < (8'hB0 & m), core_out.preempt)
            end
        end
        bus(OFF_LOW_POWER_CONTROL, 32'h00000016, 1'b1, 1'b1);
        rd_chk(OFF_LOW_POWER_CONTROL, 32'h00000016);
        `CHK("deep", 1'b1, core_out.deep_sleep)
        for (int on = 1; on >= 0; on--) begin
            c = '0;
            c.wfe_exec = 1'b1;
            pulse(c);
            `CHK("wfe_done", 1'b0, core_out.wfe_done)
            c = '0;
            c.irq_pend_new = 1'b1;
            pulse(c);
            `CHK("wake", on[0], core_out.wake)
            c = '0;
            c.handler_return = 1'b1;
            pulse(c);
            `CHK("sleep", on[0], core_out.sleep_enter)
            `CHK("deep", on[0], core_out.deep_sleep)
            bus(OFF_LOW_POWER_CONTROL, 32'h0, 1'b1, 1'b1);
        end
        c = '0;
        c.sev_exec = 1'b1;
        pulse(c);
        `CHK("sev_wake", 1'b1, core_out.wake)
        c.sev_exec = 1'b0;
        c.wfe_exec = 1'b1;
        pulse(c);
        c = '0;
        c.irq_pend_new = 1'b1;
        c.irq_pend_enabled = 1'b1;
        pulse(c);
        `CHK("en_wake", 1'b1, core_out.wake)
        c = '0;
        c.wfe_exec = 1'b1;
        pulse(c);
        @(posedge clk_i);
        ext_event_i <= 1'b1;
        seen = 1'b0;
        repeat (6) begin
            @(posedge clk_i);
            #1;
            seen = seen | core_out.wake;
        end
        @(posedge clk_i);
        ext_event_i <= 1'b0;
        `CHK("ext_wake", 1'b1, seen)
        c = '0;
        c.sev_exec = 1'b1;
        pulse(c);
        c.sev_exec = 1'b0;
        c.wfe_exec = 1'b1;
        pulse(c);
        `CHK("wfe_done", 1'b1, core_out.wfe_done)
        bus(OFF_CORE_CONFIGURATION_CONTROL, 32'h0000031B, 1'b1, 1'b1);
        rd_chk(OFF_CORE_CONFIGURATION_CONTROL, 32'h0000031B);
        c = '0;
        c.div_by_zero = 1'b1;
        c.misaligned = 1'b1;
        c.load_store_bus_fault = 1'b1;
        c.prio_neg = 1'b1;
        c.trigger_access = 1'b1;
        c.trigger_unpriv = 1'b1;
        c.thread_return = 1'b1;
        c.other_active = 1'b1;
        c.exception_return_value = 1'b1;
        c.stacked_align8 = 1'b1;
        pulse(c);
        `CHK("cfg_on", 9'h1F0, cfg_view)
        `CHK("ret_align8", 1'b1, core_out.return_align8)
        bus(OFF_CORE_CONFIGURATION_CONTROL, 32'h0, 1'b1, 1'b1);
        pulse(c);
        `CHK("cfg_off", 9'h00F, cfg_view)
        `CHK("align8", 1'b0, core_out.entry_align8)
        c.multi_or_double = 1'b1;
        pulse(c);
        `CHK("multi_fault", 1'b1, core_out.usage_fault)
        bus(OFF_CORE_CONFIGURATION_CONTROL, 32'h0000001B, 1'b1, 1'b0);
        `CHK("bus_err", 1'b1, bus_err_o)
        bus(OFF_INTERRUPT_RESET_CONTROL, 32'h0, 1'b0, 1'b0);
        `CHK("unpriv_rdata", 32'h0, rdata_o)
        rd_chk(OFF_CORE_CONFIGURATION_CONTROL, 32'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** verilog/sys_ctrl_pkg.sv ***
// Package with offsets, field layouts, reset values and carrier types of the control bank.
package sys_ctrl_pkg;

    // ****************************************************************
    // Register offsets and reset values
    // ****************************************************************
    localparam logic [7:0]  OFF_INTERRUPT_RESET_CONTROL    = 8'h0C;
    localparam logic [7:0]  OFF_LOW_POWER_CONTROL          = 8'h10;
    localparam logic [7:0]  OFF_CORE_CONFIGURATION_CONTROL = 8'h14;
    localparam logic [31:0] RST_INTERRUPT_RESET_CONTROL    = 32'hFA050000;
    localparam logic [31:0] RST_LOW_POWER_CONTROL          = 32'h00000000;
    localparam logic [31:0] RST_CORE_CONFIGURATION_CONTROL = 32'h00000200;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam logic [15:0] WRITE_UNLOCK_KEY     = 16'h05FA;
    localparam logic [15:0] UNLOCK_KEY_STATUS    = 16'hFA05;
    localparam int          KEY_LSB              = 16;
    localparam int          DATA_BYTE_ORDER_BIT  = 15;
    localparam int          SPLIT_LSB            = 8;
    localparam int          SYS_RESET_REQ_BIT    = 2;
    localparam int          DEBUG_CLEAR_ACT_BIT  = 1;
    localparam int          DEBUG_LOCAL_RST_BIT  = 0;
    localparam int          WAKE_ON_PENDING_BIT  = 4;
    localparam int          DEEP_SELECT_BIT      = 2;
    localparam int          ON_RETURN_SLEEP_BIT  = 1;
    localparam int          STACK_ALIGN_BIT      = 9;
    localparam int          BUS_FAULT_IGN_BIT    = 8;
    localparam int          ZERO_DIV_TRAP_BIT    = 4;
    localparam int          MISALIGN_TRAP_BIT    = 3;
    localparam int          TRIGGER_ACCESS_BIT   = 1;
    localparam int          THREAD_ANY_BIT       = 0;
    localparam logic [7:0]  PRIO_IMPL_MASK       = 8'hF0;
    localparam logic        DATA_BYTE_ORDER_LE   = 1'b0;

    // Split select codes for the implemented priority nibble.
    localparam logic [2:0]  SPLIT_GROUP_4 = 3'h3;
    localparam logic [2:0]  SPLIT_GROUP_3 = 3'h4;
    localparam logic [2:0]  SPLIT_GROUP_2 = 3'h5;
    localparam logic [2:0]  SPLIT_GROUP_1 = 3'h6;
    localparam logic [2:0]  SPLIT_GROUP_0 = 3'h7;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] pend_prio;
        logic [7:0] run_prio;
        logic       irq_pend_new;
        logic       irq_pend_enabled;
        logic       event_enabled;
        logic       waiting;
        logic       wfe_exec;
        logic       sev_exec;
        logic       handler_return;
        logic       exc_entry;
        logic       stacked_align8;
        logic       exception_return_value;
        logic       load_store_bus_fault;
        logic       prio_neg;
        logic       div_by_zero;
        logic       misaligned;
        logic       multi_or_double;
        logic       trigger_access;
        logic       trigger_unpriv;
        logic       thread_return;
        logic       other_active;
    } core_in_s;

    typedef struct packed {
        logic       preempt;
        logic [7:0] pend_group;
        logic       wake;
        logic       wfe_done;
        logic       sleep_enter;
        logic       deep_sleep;
        logic       entry_align8;
        logic       return_align8;
        logic       bus_fault_ignored;
        logic       lockup;
        logic       div_trap;
        logic       div_quot_zero;
        logic       usage_fault;
        logic       trigger_grant;
        logic       trigger_deny;
        logic       thread_ok;
        logic       thread_fault;
        logic       system_reset_request;
    } core_out_s;

endpackage

// *** verilog/system_control_config_regs.sv ***
// Privileged system control bank: reset/priority, low-power and configuration registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Interrupt/reset register write is dropped unless top halfword carries unlock key.
// - Top halfword of interrupt/reset register always reads the key status value.
// - Byte order bit 15 is read-only zero, meaning little-endian.
// - Bits 10:8 hold the writable three-bit priority split select.
// - Split select decides which priority nibble bits are group versus subpriority.
// - Preemption compares only group priority bits chosen by split select.
// - Writing one to bit 2 requests system reset; bit reads zero.
// - Debug bits 1 and 0 read zero; software must write zero.
// - Wake on pending lets any new pending interrupt wake, disabled included.
// - A wake event while not waiting is latched for the next wait.
// - Send-event instruction or external event input also wakes the core.
// - Low-power bit 2 selects sleep or deep sleep.
// - Low-power bit 1 sleeps on return from handler to thread mode.
// - Configuration bit 9 picks 4- or 8-byte entry stack alignment.
// - Bit 8 lets priority -1/-2 handlers ignore data bus faults, else lock-up.
// - Bit 4 traps divide by zero, otherwise quotient is zero.
// - Bit 3 makes unaligned halfword and word accesses raise usage fault.
// - Unaligned multiple and doubleword accesses always fault.
// - Bit 1 grants unprivileged access to software interrupt trigger register.
// - Bit 0 clear: thread return only with no other exception active.
// - Priority fields implement bits 7:4 only; low bits read zero.
module system_control_config_regs
    import sys_ctrl_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        priv_i,
    output logic      [31:0] rdata_o,
    output logic             bus_err_o,
    input  wire core_in_s    core_i,
    input  wire logic        ext_event_i,
    output core_out_s        core_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0] split;
        logic       wake_on_pending;
        logic       deep_low_power_select;
        logic       low_power_on_handler_return;
        logic       entry_stack_alignment;
        logic       high_prio_bus_fault_ignore;
        logic       zero_divisor_trap_en;
        logic       misaligned_access_trap_en;
        logic       unprivileged_trigger_access;
        logic       thread_entry_any_level;
        logic       evt_meta;
        logic       evt_sync;
        logic       evt_sync_d;
        logic       evt_latch;
        logic [31:0] rdata;
        logic       bus_err;
        core_out_s  out;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Mask of group bits within an 8-bit priority for a split select value.
    // Codes below the first documented one behave as all-group.
    function automatic logic [7:0] group_mask(input logic [2:0] sel);
        logic [7:0] m;
        m = 8'h00;
        case (sel)
            SPLIT_GROUP_3: m = 8'hE0;
            SPLIT_GROUP_2: m = 8'hC0;
            SPLIT_GROUP_1: m = 8'h80;
            SPLIT_GROUP_0: m = 8'h00;
            default:       m = 8'hF0;
        endcase
        return m & PRIO_IMPL_MASK;
    endfunction

    // Group portion of a priority with unimplemented low bits removed.
    function automatic logic [7:0] group_of(input logic [7:0] prio, input logic [2:0] sel);
        return prio & PRIO_IMPL_MASK & group_mask(sel);
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        acc_ok;
    logic        wr_ok;
    logic        key_ok;
    logic [31:0] irc_rd;
    logic [31:0] lpc_rd;
    logic [31:0] ccr_rd;
    logic        wake_src;
    logic        wfe_now;

    always_comb begin
        nxt_st = st_ff;
        acc_ok = priv_i;
        wr_ok  = wr_i & acc_ok;
        key_ok = (wdata_i[31:KEY_LSB] == WRITE_UNLOCK_KEY);

        irc_rd = 32'h00000000;
        irc_rd[31:KEY_LSB] = UNLOCK_KEY_STATUS;
        irc_rd[DATA_BYTE_ORDER_BIT] = DATA_BYTE_ORDER_LE;
        irc_rd[SPLIT_LSB +: 3] = st_ff.split;
        // Reset request and both debug bits stay zero in the read image.
        irc_rd[SYS_RESET_REQ_BIT] = 1'b0;
        irc_rd[DEBUG_CLEAR_ACT_BIT] = 1'b0;
        irc_rd[DEBUG_LOCAL_RST_BIT] = 1'b0;

        lpc_rd = 32'h00000000;
        lpc_rd[WAKE_ON_PENDING_BIT] = st_ff.wake_on_pending;
        lpc_rd[DEEP_SELECT_BIT]     = st_ff.deep_low_power_select;
        lpc_rd[ON_RETURN_SLEEP_BIT] = st_ff.low_power_on_handler_return;

        ccr_rd = 32'h00000000;
        ccr_rd[STACK_ALIGN_BIT]    = st_ff.entry_stack_alignment;
        ccr_rd[BUS_FAULT_IGN_BIT]  = st_ff.high_prio_bus_fault_ignore;
        ccr_rd[ZERO_DIV_TRAP_BIT]  = st_ff.zero_divisor_trap_en;
        ccr_rd[MISALIGN_TRAP_BIT]  = st_ff.misaligned_access_trap_en;
        ccr_rd[TRIGGER_ACCESS_BIT] = st_ff.unprivileged_trigger_access;
        ccr_rd[THREAD_ANY_BIT]     = st_ff.thread_entry_any_level;

        // Register writes.
        nxt_st.out.system_reset_request = 1'b0;
        if (wr_ok) begin
            case (addr_i)
                OFF_INTERRUPT_RESET_CONTROL: begin
                    if (key_ok) begin
                        nxt_st.split = wdata_i[SPLIT_LSB +: 3];
                        nxt_st.out.system_reset_request = wdata_i[SYS_RESET_REQ_BIT];
                    end
                end
                OFF_LOW_POWER_CONTROL: begin
                    nxt_st.wake_on_pending             = wdata_i[WAKE_ON_PENDING_BIT];
                    nxt_st.deep_low_power_select       = wdata_i[DEEP_SELECT_BIT];
                    nxt_st.low_power_on_handler_return = wdata_i[ON_RETURN_SLEEP_BIT];
                end
                OFF_CORE_CONFIGURATION_CONTROL: begin
                    nxt_st.entry_stack_alignment       = wdata_i[STACK_ALIGN_BIT];
                    nxt_st.high_prio_bus_fault_ignore  = wdata_i[BUS_FAULT_IGN_BIT];
                    nxt_st.zero_divisor_trap_en        = wdata_i[ZERO_DIV_TRAP_BIT];
                    nxt_st.misaligned_access_trap_en   = wdata_i[MISALIGN_TRAP_BIT];
                    nxt_st.unprivileged_trigger_access = wdata_i[TRIGGER_ACCESS_BIT];
                    nxt_st.thread_entry_any_level      = wdata_i[THREAD_ANY_BIT];
                end
                default: begin
                end
            endcase
        end

        // Register reads; data stand one cycle after the strobe only.
        nxt_st.rdata = 32'h00000000;
        if (rd_i && acc_ok) begin
            case (addr_i)
                OFF_INTERRUPT_RESET_CONTROL:    nxt_st.rdata = irc_rd;
                OFF_LOW_POWER_CONTROL:          nxt_st.rdata = lpc_rd;
                OFF_CORE_CONFIGURATION_CONTROL: nxt_st.rdata = ccr_rd;
                default:                        nxt_st.rdata = 32'h00000000;
            endcase
        end
        nxt_st.bus_err = (rd_i | wr_i) & ~acc_ok;

        // Preemption on group priority only; lower value is more urgent.
        nxt_st.out.pend_group = group_of(core_i.pend_prio, st_ff.split);
        nxt_st.out.preempt    = group_of(core_i.pend_prio, st_ff.split)
                              < group_of(core_i.run_prio, st_ff.split);

        // The event pin is asynchronous; a rising edge of the second stage, found against the third, is used.
        nxt_st.evt_meta   = ext_event_i;
        nxt_st.evt_sync   = st_ff.evt_meta;
        nxt_st.evt_sync_d = st_ff.evt_sync;

        wake_src = (core_i.irq_pend_new
                    & (core_i.irq_pend_enabled | st_ff.wake_on_pending))
                 | core_i.event_enabled
                 | core_i.sev_exec
                 | (st_ff.evt_sync & ~st_ff.evt_sync_d);

        // A wait that finds the latch set finishes at once and consumes it;
        // a new source in that same cycle sets the latch again.
        wfe_now            = core_i.wfe_exec & st_ff.evt_latch;
        nxt_st.out.wfe_done = wfe_now;
        nxt_st.out.wake     = wake_src & core_i.waiting;
        nxt_st.evt_latch    = (st_ff.evt_latch & ~wfe_now)
                            | (wake_src & ~core_i.waiting);

        // Low-power entry on handler return.
        nxt_st.out.sleep_enter = core_i.handler_return
                               & st_ff.low_power_on_handler_return;
        nxt_st.out.deep_sleep  = st_ff.deep_low_power_select;

        // Stack alignment chosen on entry, restored from the stacked word on return.
        nxt_st.out.entry_align8 = st_ff.entry_stack_alignment;
        if (core_i.exception_return_value) begin
            nxt_st.out.return_align8 = core_i.stacked_align8;
        end

        // Data bus fault under priority -1 or -2.
        nxt_st.out.bus_fault_ignored = core_i.load_store_bus_fault & core_i.prio_neg
                                     & st_ff.high_prio_bus_fault_ignore;
        nxt_st.out.lockup = core_i.load_store_bus_fault & core_i.prio_neg
                          & ~st_ff.high_prio_bus_fault_ignore;

        // Divide by zero.
        nxt_st.out.div_trap      = core_i.div_by_zero & st_ff.zero_divisor_trap_en;
        nxt_st.out.div_quot_zero = core_i.div_by_zero & ~st_ff.zero_divisor_trap_en;

        // Misaligned accesses.
        nxt_st.out.usage_fault = core_i.misaligned
                               & (st_ff.misaligned_access_trap_en
                                  | core_i.multi_or_double);

        // Software interrupt trigger register access.
        nxt_st.out.trigger_grant = core_i.trigger_access
                                 & (~core_i.trigger_unpriv
                                    | st_ff.unprivileged_trigger_access);
        nxt_st.out.trigger_deny  = core_i.trigger_access & core_i.trigger_unpriv
                                 & ~st_ff.unprivileged_trigger_access;

        // Return to thread mode.
        nxt_st.out.thread_ok    = core_i.thread_return
                                & (~core_i.other_active | st_ff.thread_entry_any_level);
        nxt_st.out.thread_fault = core_i.thread_return & core_i.other_active
                                & ~st_ff.thread_entry_any_level;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.split <= RST_INTERRUPT_RESET_CONTROL[SPLIT_LSB +: 3];
            st_ff.wake_on_pending <= RST_LOW_POWER_CONTROL[WAKE_ON_PENDING_BIT];
            st_ff.deep_low_power_select <= RST_LOW_POWER_CONTROL[DEEP_SELECT_BIT];
            st_ff.low_power_on_handler_return <= RST_LOW_POWER_CONTROL[ON_RETURN_SLEEP_BIT];
            st_ff.entry_stack_alignment <= RST_CORE_CONFIGURATION_CONTROL[STACK_ALIGN_BIT];
            st_ff.out.entry_align8 <= RST_CORE_CONFIGURATION_CONTROL[STACK_ALIGN_BIT];
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o   = st_ff.rdata;
    assign bus_err_o = st_ff.bus_err;
    assign core_o    = st_ff.out;

endmodule

`default_nettype wire
